// ===== hdl/aof_accel_format.sv
`timescale 1ns/1ps
module aof_accel_format
    import aof_pkg::*;
#(
    parameter int RAW_W = 16
) (
    input  wire logic              clock,
    input  wire logic              rst_n,
    input  wire logic signed [RAW_W-1:0] accel_x_mg,
    input  wire logic signed [RAW_W-1:0] accel_y_mg,
    input  wire logic signed [RAW_W-1:0] accel_z_mg,
    input  wire logic              sample_valid,
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [DATA_W-1:0] reg_wdata,
    input  wire logic              reg_write,
    input  wire logic              reg_read,
    output logic [DATA_W-1:0]      reg_rdata,
    input  wire logic              device_select_n,
    input  wire logic              spi_sclk,
    input  wire logic              spi_mosi,
    output logic                   spi_miso,
    output logic                   spi_miso_oe,
    output logic                   accel_int,
    output logic                   selftest_drive,
    output logic                   range_10g_drive
);

    typedef enum logic [2:0] {
        AOF_IDLE = 3'b001,
        AOF_CMD  = 3'b010,
        AOF_DATA = 3'b100
    } aof_spi_state_t;

    // ==========================================================
    // Control register
    logic [CTRL_W-1:0]       ctrl_reg;
    logic [CODE_W-1:0]       code_reg [3];
    logic                    new_data_reg;
    logic                    spi_wr_pulse;
    logic [ADDR_W-1:0]       spi_addr_reg;
    logic [DATA_W-1:0]       spi_shift_reg;

    // Plain port wins when both sources write in the same cycle
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg <= CTRL_RESET;
        end else if (reg_write && reg_addr == OFS_CTRL) begin
            ctrl_reg <= reg_wdata[CTRL_W-1:0];
        end else if (spi_wr_pulse && spi_addr_reg == OFS_CTRL) begin
            ctrl_reg <= spi_shift_reg[CTRL_W-1:0];
        end
    end

    // ==========================================================
    // Actuator drives
    // Registered copies keep the pins glitch free while software rewrites control
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            selftest_drive <= 1'b0;
        end else begin
            selftest_drive <= ctrl_reg[CTRL_SELFTEST];
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            range_10g_drive <= 1'b0;
        end else begin
            range_10g_drive <= ctrl_reg[CTRL_RANGE10G];
        end
    end

    // ==========================================================
    // Per-axis formatting
    logic signed [RAW_W-1:0] raw_in [3];
    logic [CODE_W-1:0]       code_next [3];

    assign raw_in[0] = accel_x_mg;
    assign raw_in[1] = accel_y_mg;
    assign raw_in[2] = accel_z_mg;

    // Input sign already follows the axis reference direction; no inversion here
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_axis
            logic signed [RAW_W+1:0] q2g;
            logic signed [RAW_W+1:0] q10g;
            logic signed [RAW_W+1:0] scaled;
            logic signed [RAW_W+1:0] offset;
            logic signed [RAW_W+1:0] sum;
            logic signed [RAW_W+1:0] sat;

            always_comb begin
                // Floor division keeps -1 step as all ones in both ranges
                q2g  = (RAW_W+2)'(raw_in[g]) >>> $clog2(STEP_2G_MG);
                if (q2g < 0) begin
                    q10g = (q2g - (RAW_W+2)'(RANGE_RATIO - 1)) / (RAW_W+2)'(RANGE_RATIO);
                end else begin
                    q10g = q2g / (RAW_W+2)'(RANGE_RATIO);
                end
                scaled = ctrl_reg[CTRL_RANGE10G] ? q10g : q2g;
                if (!ctrl_reg[CTRL_SELFTEST]) begin
                    offset = '0;
                end else if (ctrl_reg[CTRL_RANGE10G]) begin
                    offset = (RAW_W+2)'(ST_OFS_10G);
                end else begin
                    offset = (RAW_W+2)'(ST_OFS_2G);
                end
                sum = scaled + offset;
                if (sum > (RAW_W+2)'(signed'(CODE_MAX))) begin
                    sat = (RAW_W+2)'(signed'(CODE_MAX));
                end else if (sum < -(RAW_W+2)'(signed'(CODE_MAX)) - 1) begin
                    sat = (RAW_W+2)'(-(RAW_W+2)'(signed'(CODE_MAX)) - 1);
                end else begin
                    sat = sum;
                end
                code_next[g] = sat[CODE_W-1:0];
                if (ctrl_reg[CTRL_LOWPOWER]) begin
                    // Reduced resolution: low bits dropped, still monotonic
                    code_next[g][LP_DROP-1:0] = '0;
                end
            end

            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    code_reg[g] <= '0;
                end else if (sample_valid) begin
                    code_reg[g] <= code_next[g];
                end
            end
        end
    endgenerate

    // ==========================================================
    // Register read mux
    function automatic logic [DATA_W-1:0] read_mux(input logic [ADDR_W-1:0] a);
        logic [DATA_W-1:0] v;
        v = '0;
        unique case (a)
            OFS_CTRL:   v[CTRL_W-1:0] = ctrl_reg;
            OFS_X:      v = {{(DATA_W-CODE_W){code_reg[0][CODE_W-1]}}, code_reg[0]};
            OFS_Y:      v = {{(DATA_W-CODE_W){code_reg[1][CODE_W-1]}}, code_reg[1]};
            OFS_Z:      v = {{(DATA_W-CODE_W){code_reg[2][CODE_W-1]}}, code_reg[2]};
            OFS_STATUS: begin
                v[STAT_NEWDATA]  = new_data_reg;
                v[STAT_SELFTEST] = ctrl_reg[CTRL_SELFTEST];
            end
            default:    v = '0;
        endcase
        return v;
    endfunction : read_mux

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= '0;
        end else if (reg_read) begin
            reg_rdata <= read_mux(reg_addr);
        end else begin
            reg_rdata <= '0;
        end
    end

    // ==========================================================
    // Serial pin synchronisers
    logic [1:0] sel_sync_reg;
    logic [1:0] sck_sync_reg;
    logic [1:0] mosi_sync_reg;
    logic       sck_prev_reg;

    // Select resets to its idle level so reset release never looks like a frame start
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sel_sync_reg <= 2'h3;
        end else begin
            sel_sync_reg <= {sel_sync_reg[0], device_select_n};
        end
    end

    // Serial clock idles low in mode 0, so a low reset value gives no false edge
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sck_sync_reg <= 2'h0;
        end else begin
            sck_sync_reg <= {sck_sync_reg[0], spi_sclk};
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            mosi_sync_reg <= 2'h0;
        end else begin
            mosi_sync_reg <= {mosi_sync_reg[0], spi_mosi};
        end
    end

    // Edge detection reads only the settled second stage
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sck_prev_reg <= 1'b0;
        end else begin
            sck_prev_reg <= sck_sync_reg[1];
        end
    end

    logic selected;
    logic sck_rise;
    logic sck_fall;
    assign selected = !sel_sync_reg[1];
    assign sck_rise = sck_sync_reg[1] && !sck_prev_reg;
    assign sck_fall = !sck_sync_reg[1] && sck_prev_reg;

    // ==========================================================
    // Serial frame engine (mode 0, MSB first)
    aof_spi_state_t    spi_state_reg;
    logic [CNT_W-1:0]  bit_cnt_reg;
    logic              spi_read_reg;
    logic [DATA_W-1:0] spi_out_reg;
    logic              spi_rd_pulse;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            spi_state_reg <= AOF_IDLE;
            bit_cnt_reg   <= '0;
            spi_read_reg  <= 1'b0;
            spi_addr_reg  <= '0;
            spi_shift_reg <= '0;
            spi_wr_pulse  <= 1'b0;
            spi_rd_pulse  <= 1'b0;
        end else begin
            spi_wr_pulse <= 1'b0;
            spi_rd_pulse <= 1'b0;
            if (!selected) begin
                // Deselect aborts any partial frame
                spi_state_reg <= AOF_IDLE;
                bit_cnt_reg   <= '0;
            end else begin
                unique case (spi_state_reg)
                    AOF_IDLE: begin
                        spi_state_reg <= AOF_CMD;
                        bit_cnt_reg   <= '0;
                    end
                    AOF_CMD: begin
                        if (sck_rise) begin
                            spi_shift_reg <= {spi_shift_reg[DATA_W-2:0], mosi_sync_reg[1]};
                            bit_cnt_reg   <= bit_cnt_reg + 1'b1;
                            if (bit_cnt_reg == CNT_W'(CMD_W - 1)) begin
                                spi_read_reg  <= spi_shift_reg[CMD_W-2];
                                spi_addr_reg  <= {spi_shift_reg[ADDR_W-2:0], mosi_sync_reg[1]};
                                spi_rd_pulse  <= 1'b1;
                                spi_state_reg <= AOF_DATA;
                            end
                        end
                    end
                    AOF_DATA: begin
                        if (sck_rise) begin
                            spi_shift_reg <= {spi_shift_reg[DATA_W-2:0], mosi_sync_reg[1]};
                            bit_cnt_reg   <= bit_cnt_reg + 1'b1;
                            if (bit_cnt_reg == CNT_W'(FRAME_W - 1)) begin
                                spi_wr_pulse  <= !spi_read_reg;
                                spi_state_reg <= AOF_IDLE;
                            end
                        end
                    end
                endcase
            end
        end
    end

    // ==========================================================
    // Serial data out
    // Read data is captured once the address is known, shifted on falling clock
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            spi_out_reg <= '0;
        end else if (spi_rd_pulse) begin
            spi_out_reg <= spi_read_reg ? read_mux(spi_addr_reg) : '0;
        end else if (spi_state_reg == AOF_DATA && sck_fall) begin
            spi_out_reg <= {spi_out_reg[DATA_W-2:0], 1'b0};
        end
    end

    // Line held low while deselected so a shared bus sees no stale bit
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            spi_miso <= 1'b0;
        end else if (!selected) begin
            spi_miso <= 1'b0;
        end else if (!spi_rd_pulse && spi_state_reg == AOF_DATA && sck_fall) begin
            spi_miso <= spi_out_reg[DATA_W-1];
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            spi_miso_oe <= 1'b0;
        end else begin
            spi_miso_oe <= selected;
        end
    end

    // ==========================================================
    // New-data flag drives the interrupt pin; a new sample beats a clearing read
    logic data_read;
    logic plain_axis_rd;
    logic spi_axis_rd;
    assign plain_axis_rd = reg_read && (reg_addr == OFS_X || reg_addr == OFS_Y || reg_addr == OFS_Z);
    assign spi_axis_rd   = spi_rd_pulse && spi_read_reg
                         && (spi_addr_reg == OFS_X || spi_addr_reg == OFS_Y || spi_addr_reg == OFS_Z);
    assign data_read     = plain_axis_rd || spi_axis_rd;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            new_data_reg <= 1'b0;
        end else if (sample_valid) begin
            new_data_reg <= 1'b1;
        end else if (data_read) begin
            new_data_reg <= 1'b0;
        end
    end

    // One cycle of lag buys a clean flop-driven pin
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            accel_int <= 1'b0;
        end else begin
            accel_int <= new_data_reg;
        end
    end

endmodule : aof_accel_format

// ===== hdl/aof_pkg.sv
// Behaviour
// - Each axis reads as a 10-bit two's-complement code; 2g step is 4 mg.
// - Zero is all zeros, one step below is all ones, codes rise monotonically; low-power mode clears the 3 low bits, so one step below reads 0x3F8.
// - The 10g range uses the same code sequence with a five-times wider step.
// - Host writes one to the self-test bit; device then applies the test deflection.
// - Self test works in both ranges and both power modes, all axes together.
// - Active self test shifts output 300 counts at 2g, 60 counts at 10g.
// - The self-test shift stays constant until the host writes the bit to zero.
// - During self test the output is measured acceleration plus offset, never replaced.
// - Acceleration along an axis reference direction gives a positive code.
// - SPI slave with active-low select, clock, data in, data out, plus interrupt pin.
// - Three separate 10-bit signed codes are held, one per axis.
package aof_pkg;

    // ==========================================================
    // Register map
    localparam int          ADDR_W       = 7;
    localparam int          DATA_W       = 16;
    localparam logic [6:0]  OFS_CTRL     = 7'h00;
    localparam logic [6:0]  OFS_X        = 7'h01;
    localparam logic [6:0]  OFS_Y        = 7'h02;
    localparam logic [6:0]  OFS_Z        = 7'h03;
    localparam logic [6:0]  OFS_STATUS   = 7'h04;

    // ==========================================================
    // Control fields
    localparam int          CTRL_SELFTEST = 0;
    localparam int          CTRL_RANGE10G = 1;
    localparam int          CTRL_LOWPOWER = 2;
    localparam int          CTRL_W        = 3;
    localparam logic [2:0]  CTRL_RESET    = 3'h0;

    // ==========================================================
    // Status fields
    localparam int          STAT_NEWDATA  = 0;
    localparam int          STAT_SELFTEST = 1;

    // ==========================================================
    // Output code
    localparam int            CODE_W      = 10;
    localparam logic [9:0]    CODE_MAX    = 10'h1FF;
    localparam logic [9:0]    CODE_MIN    = 10'h200;
    localparam int            STEP_2G_MG  = 4;
    localparam int            RANGE_RATIO = 5;
    localparam logic [9:0]    ST_OFS_2G   = 10'h12C;
    localparam logic [9:0]    ST_OFS_10G  = 10'h03C;
    localparam int            LP_DROP     = 3;

    // ==========================================================
    // Serial frame: command byte (read flag, address) then data word
    localparam int          CMD_W         = 8;
    localparam int          FRAME_W       = CMD_W + DATA_W;
    localparam int          CNT_W         = 5;

endpackage : aof_pkg

// ===== test/aof_accel_format_properties.sv
`timescale 1ns/1ps
module aof_accel_format_properties
    import aof_pkg::*;
(
    input wire logic              clock,
    input wire logic              rst_n,
    input wire logic              sample_valid,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic              reg_write,
    input wire logic              reg_read,
    input wire logic [DATA_W-1:0] reg_rdata,
    input wire logic              device_select_n,
    input wire logic              spi_miso,
    input wire logic              spi_miso_oe,
    input wire logic              accel_int,
    input wire logic              selftest_drive,
    input wire logic              range_10g_drive
);
    // ==========================================
    // Checks
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    logic ctrl_wr;
    logic axis_rd;
    assign ctrl_wr = reg_write && reg_addr == OFS_CTRL;
    assign axis_rd = reg_read && reg_addr >= OFS_X && reg_addr <= OFS_Z;
    a_st_on_drive: assert property (ctrl_wr && reg_wdata[CTRL_SELFTEST] |-> ##2 selftest_drive)
        else $error("self test drive not raised");
    a_st_off_drive: assert property (ctrl_wr && !reg_wdata[CTRL_SELFTEST] |-> ##2 !selftest_drive)
        else $error("self test drive not dropped");
    a_range_drive: assert property (ctrl_wr && reg_wdata[CTRL_RANGE10G] |-> ##2 range_10g_drive)
        else $error("range drive not raised");
    a_ctrl_readback: assert property (reg_read && reg_addr == OFS_CTRL |=>
        reg_rdata[1:0] == {range_10g_drive, selftest_drive}) else $error("control readback differs");
    a_status_st: assert property (reg_read && reg_addr == OFS_STATUS |=>
        reg_rdata[STAT_SELFTEST] == selftest_drive) else $error("status self test bit differs");
    a_unmapped_zero: assert property (reg_read && reg_addr > OFS_STATUS |=> reg_rdata == '0)
        else $error("unmapped read not zero");
    a_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == '0)
        else $error("read data outside its cycle");
    a_code_sign: assert property (axis_rd |=> reg_rdata[15:10] == {6{reg_rdata[9]}})
        else $error("axis code not sign extended");
    a_int_set: assert property (sample_valid |-> ##2 accel_int)
        else $error("data ready not raised");
    a_int_clear: assert property (axis_rd && !sample_valid |-> ##2 !accel_int)
        else $error("data ready not cleared");
    a_oe_release: assert property (device_select_n [*5] |-> !spi_miso_oe && !spi_miso)
        else $error("data out driven while deselected");
    a_reset_clear: assert property ($rose(rst_n) |-> !selftest_drive && !accel_int)
        else $error("outputs not clear after reset");
endmodule : aof_accel_format_properties

// ===== test/aof_spi_host.sv
`timescale 1ns/1ps
module aof_spi_host (
    input  wire logic clock,
    input  wire logic spi_miso,
    output logic      device_select_n,
    output logic      spi_sclk,
    output logic      spi_mosi
);
    // ==========================================
    // Mode 0 master; half period well above the three-cycle minimum
    localparam int HALF = 6;
    initial begin
        device_select_n = 1'b1;
        spi_sclk = 1'b0;
        spi_mosi = 1'b0;
    end
    task automatic xfer(input logic [23:0] frame, output logic [15:0] rdata);
        device_select_n <= 1'b0;
        for (int i = 23; i >= 0; i--) begin
            spi_mosi <= frame[i];
            repeat (HALF) @(posedge clock);
            spi_sclk <= 1'b1;
            if (i < 16) rdata[i] = spi_miso;
            repeat (HALF) @(posedge clock);
            spi_sclk <= 1'b0;
        end
        repeat (HALF) @(posedge clock);
        device_select_n <= 1'b1;
        // Released line: no pull, so never leave the last bit standing
        spi_mosi <= ~spi_mosi;
        repeat (HALF) @(posedge clock);
    endtask : xfer
endmodule : aof_spi_host

// ===== test/tb.sv
`timescale 1ns/1ps
module tb import aof_pkg::*;;
    // ==========================================
    // Signals
    logic               clock;
    logic               rst_n = 1'b0;
    logic signed [15:0] acc_x = '0;
    logic signed [15:0] acc_y = '0;
    logic signed [15:0] acc_z = '0;
    logic               sample_valid = 1'b0;
    logic [ADDR_W-1:0]  reg_addr = '0;
    logic [DATA_W-1:0]  reg_wdata = '0;
    logic               reg_write = 1'b0;
    logic               reg_read = 1'b0;
    logic [DATA_W-1:0]  reg_rdata;
    logic               device_select_n, spi_sclk, spi_mosi, spi_miso, spi_miso_oe;
    logic               accel_int, selftest_drive, range_10g_drive;
    int                 mismatches = 0;
    int                 n_tests = 0;
    int                 corner[11] = '{0, -1, -4, 3, 4, -2048, 2044, 10236, -10240, 20000, -20000};
    aof_accel_format #(.RAW_W(16)) i_aof_accel_format (.clock(clock), .rst_n(rst_n), .accel_x_mg(acc_x),
        .accel_y_mg(acc_y), .accel_z_mg(acc_z), .sample_valid(sample_valid), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .device_select_n(device_select_n), .spi_sclk(spi_sclk), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
        .spi_miso_oe(spi_miso_oe), .accel_int(accel_int), .selftest_drive(selftest_drive),
        .range_10g_drive(range_10g_drive));
    aof_spi_host i_aof_spi_host (.clock(clock), .spi_miso(spi_miso), .device_select_n(device_select_n),
        .spi_sclk(spi_sclk), .spi_mosi(spi_mosi));
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    // ==========================================
    // Helpers
    function automatic logic [15:0] exp_code(input int mg, input logic [2:0] c);
        int d;
        int q;
        d = c[CTRL_RANGE10G] ? STEP_2G_MG * RANGE_RATIO : STEP_2G_MG;
        q = mg / d - ((mg % d != 0 && mg < 0) ? 1 : 0);
        if (c[CTRL_SELFTEST]) q += c[CTRL_RANGE10G] ? int'(ST_OFS_10G) : int'(ST_OFS_2G);
        q = q > 511 ? 511 : (q < -512 ? -512 : q);
        if (c[CTRL_LOWPOWER]) q = q & -8;
        return 16'(q);
    endfunction : exp_code
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask : wr
    task automatic rd(input logic [6:0] a, output logic [15:0] d);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        @(posedge clock);
        d = reg_rdata;
    endtask : rd
    task automatic samp(input int x, input int y, input int z);
        acc_x <= 16'(x);
        acc_y <= 16'(y);
        acc_z <= 16'(z);
        sample_valid <= 1'b1;
        @(posedge clock);
        sample_valid <= 1'b0;
    endtask : samp
    task automatic apply(input int v[3], input logic [2:0] c);
        logic [15:0] d;
        wr(OFS_CTRL, {13'h0, c});
        samp(v[0], v[1], v[2]);
        for (int a = 0; a < 3; a++) begin
            rd(OFS_X + 7'(a), d);
            chk(d, exp_code(v[a], c));
        end
    endtask : apply
    task automatic print_verdict();
        $display("checks=%0d mismatches=%0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : print_verdict
    // ==========================================
    // Tests
    initial begin
        logic [15:0] d;
        void'($urandom(32'h46EA48A5));
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        rd(OFS_CTRL, d);
        chk(d, 16'h0000);
        $display("test reset done");
        for (int c = 0; c < 8; c++) begin
            foreach (corner[i]) apply('{corner[i], -corner[i], corner[i] / 2}, 3'(c));
        end
        $display("test corners done");
        repeat (150) apply('{int'($urandom_range(24000)) - 12000, int'($urandom_range(24000)) - 12000,
            int'($urandom_range(24000)) - 12000}, 3'($urandom_range(7)));
        $display("test random done");
        wr(OFS_CTRL, 16'h0000);
        samp(-1, 0, 0);
        wr(OFS_X, 16'h0155);
        rd(OFS_X, d);
        chk(d, exp_code(-1, 3'h0));
        rd(7'h7F, d);
        chk(d, 16'h0000);
        samp(400, 8, -8);
        repeat (2) @(posedge clock);
        chk({15'h0, accel_int}, 16'h0001);
        i_aof_spi_host.xfer({1'b0, OFS_CTRL, 16'h0001}, d);
        chk({15'h0, selftest_drive}, 16'h0001);
        samp(400, 8, -8);
        i_aof_spi_host.xfer({1'b1, OFS_X, 16'h0000}, d);
        chk(d, exp_code(400, 3'h1));
        repeat (2) @(posedge clock);
        chk({15'h0, accel_int}, 16'h0000);
        $display("test serial done");
        print_verdict();
    end
    // Corner and random passes need about 1900 cycles; allow over eight times that
    initial begin
        repeat (16000) @(posedge clock);
        mismatches++;
        print_verdict();
    end
endmodule : tb
bind aof_accel_format aof_accel_format_properties i_props (.clock(clock), .rst_n(rst_n),
    .sample_valid(sample_valid), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .device_select_n(device_select_n), .spi_miso(spi_miso),
    .spi_miso_oe(spi_miso_oe), .accel_int(accel_int), .selftest_drive(selftest_drive),
    .range_10g_drive(range_10g_drive));
